// >>> common/crsw_pkg.sv
/*
 * crsw_pkg: shared constants and types for the core register set and status word.
 * Assumes the execution pipeline uses these encodings for register indices and status views.
 */
package crsw_pkg;
    localparam int XLEN = 32;
    localparam int NUM_GP = 13;
    // register indices
    localparam logic [3:0] IDX_SP = 4'hD;
    localparam logic [3:0] IDX_LR = 4'hE;
    localparam logic [3:0] IDX_PC = 4'hF;
    // vector table addresses
    localparam logic [31:0] ADDR_SP_VEC = 32'h00000000;
    localparam logic [31:0] ADDR_RESET_VEC = 32'h00000004;
    // status word field positions
    localparam int FLAG_N_BIT = 31;
    localparam int FLAG_Z_BIT = 30;
    localparam int FLAG_C_BIT = 29;
    localparam int FLAG_V_BIT = 28;
    localparam int TBIT_POS = 24;
    localparam int EXC_NUM_W = 6;
    localparam logic [31:0] FLAG_MASK = 32'hF0000000;
    localparam logic [31:0] EXC_MASK = 32'h0000003F;
    localparam logic [31:0] EXEC_MASK = 32'h01000000;
    // reset values
    localparam logic [5:0] EXC_NUM_RST = 6'h00;
    localparam logic PRIO_MASK_RST = 1'b0;
    localparam logic [1:0] CONTROL_RST = 2'h0;
    // exception numbers
    localparam logic [5:0] EXC_THREAD = 6'h00;
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
    localparam logic [5:0] EXC_SUPERVISOR_CALL = 6'h0B;
    localparam logic [5:0] EXC_PENDABLE_SERVICE = 6'h0E;
    localparam logic [5:0] EXC_SYSTEM_TICK = 6'h0F;
    localparam logic [5:0] EXC_EXT_IRQ_FIRST = 6'h10;
    localparam logic [5:0] EXC_EXT_IRQ_LAST = 6'h2F;

    // status views addressed by move instructions
    typedef enum logic [2:0] {
        VIEW_FLAGS = 3'h0,
        VIEW_EXC = 3'h1,
        VIEW_EXEC = 3'h2,
        VIEW_EXC_FLAG = 3'h3,
        VIEW_EXEC_FLAG = 3'h4,
        VIEW_EXC_EXEC = 3'h5,
        VIEW_ALL = 3'h6
    } crsw_view_t;

    // special registers selected by moves, the status word among them
    typedef enum logic [1:0] {
        SPEC_STATUS = 2'h0,
        SPEC_PRIO_MASK = 2'h1,
        SPEC_CONTROL = 2'h2,
        SPEC_STACK = 2'h3
    } crsw_spec_t;

    // general register access from the pipeline
    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [31:0] data;
    } crsw_gpw_t;

    // special register move request
    typedef struct packed {
        logic we;
        crsw_spec_t sel;
        crsw_view_t view;
        logic proc_sel;
        logic [31:0] data;
    } crsw_spec_req_t;
endpackage

// >>> hdl/crsw_core_regs.sv
/*
 * crsw_core_regs: core register set, stack pointers and composite status word.
 * Assumes the execution pipeline drives synchronous requests and supplies the
 * two vector words during the reset load sequence.
 */
// What this block does
// - thirteen 32-bit general registers, undefined at reset
// - index 13 picks main or process pointer
// - main pointer loaded from word zero
// - index 14 is link, undefined at reset
// - index 15 program address from vector four
// - vector bit zero loads instruction-state bit
// - status word: three non-overlapping fields
// - seven views; exception-plus-execution view read-only
// - writes never change exception number
// - execution field reads zero, ignores writes
// - flags N Z C V in bits 31-28
// - exception number bits 5-0, resets zero
// - exception number encoding, others reserved
// - instruction-state bit at position 24
// - branches, returns, entry may clear bit
// - executing with bit clear raises fault
// - priority mask and control reset zero
// - access types apply to instruction access
// - handler mode: stack select reads zero
// - control bit zero: unprivileged thread mode
`timescale 1ns/1ps
module crsw_core_regs
    import crsw_pkg::*;
#(
    parameter int GP_COUNT = NUM_GP
)(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    // reset vector load
    output logic [31:0] O_VEC_ADDR,
    output logic O_VEC_REQ,
    input wire logic I_VEC_VALID,
    input wire logic [31:0] I_VEC_DATA,
    output logic O_RST_DONE,
    // general register ports
    input wire crsw_gpw_t I_GP_WR,
    input wire logic [3:0] I_GP_RIDX_A,
    input wire logic [3:0] I_GP_RIDX_B,
    output logic [31:0] O_GP_RDATA_A,
    output logic [31:0] O_GP_RDATA_B,
    // flags from the alu
    input wire logic I_FLAGS_WE,
    input wire logic [3:0] I_FLAGS,
    // special register moves
    input wire crsw_spec_req_t I_SPEC,
    output logic [31:0] O_SPEC_RDATA,
    // exception and state-bit updates
    input wire logic I_EXC_WE,
    input wire logic [5:0] I_EXC_NUM,
    input wire logic I_TBIT_WE,
    input wire logic I_TBIT,
    input wire logic I_CTRL_HW_WE,
    input wire logic [1:0] I_CTRL_HW,
    input wire logic I_EXEC_VALID,
    // state shown to the rest of the core
    output logic O_HANDLER_MODE,
    output logic O_UNPRIV,
    output logic O_USE_PROC,
    output logic O_PRIO_MASK,
    output logic [3:0] O_FLAGS,
    output logic [5:0] O_EXC_NUM,
    output logic O_TBIT,
    output logic O_TBIT_FAULT
);
    typedef enum {ST_FETCH_SP, ST_FETCH_PC, ST_RUN} crsw_rst_t;

    crsw_rst_t state_ff, nxt_state;
    logic [31:0] gp_ff [GP_COUNT];
    logic [31:0] nxt_gp [GP_COUNT];
    logic [31:0] main_ptr_ff, nxt_main_ptr;
    logic [31:0] proc_ptr_ff, nxt_proc_ptr;
    logic [31:0] lr_ff, nxt_lr;
    logic [31:0] pc_ff, nxt_pc;
    logic [3:0] flags_ff, nxt_flags;
    logic [5:0] exc_ff, nxt_exc;
    logic tbit_ff, nxt_tbit;
    logic prio_mask_ff, nxt_prio_mask;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic fault_ff, nxt_fault;
    logic [31:0] view_rdata;
    logic handler;
    logic active_proc;
    logic spec_wr_ok;
    logic [31:0] active_sp;

    assign handler = (exc_ff != EXC_THREAD);
    assign active_proc = ctrl_ff[1] && !handler;
    assign active_sp = active_proc ? proc_ptr_ff : main_ptr_ff;

    // views read-only where the combination demands it
    assign spec_wr_ok = I_SPEC.we && !(I_SPEC.sel == SPEC_STATUS && I_SPEC.view == VIEW_EXC_EXEC);

    crsw_status_view u_view (
        .i_view(I_SPEC.view),
        .i_flags(flags_ff),
        .i_exc_num(exc_ff),
        .o_rdata(view_rdata)
    );

    // reset load sequence: stack word, then reset vector
    always_comb begin
        nxt_state = state_ff;
        O_VEC_REQ = 1'b0;
        O_VEC_ADDR = ADDR_SP_VEC;
        case (state_ff)
            ST_FETCH_SP: begin
                O_VEC_REQ = 1'b1;
                O_VEC_ADDR = ADDR_SP_VEC;
                if (I_VEC_VALID) begin
                    nxt_state = ST_FETCH_PC;
                end
            end
            ST_FETCH_PC: begin
                O_VEC_REQ = 1'b1;
                O_VEC_ADDR = ADDR_RESET_VEC;
                if (I_VEC_VALID) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: ;
            default: nxt_state = ST_FETCH_SP;
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_ff <= ST_FETCH_SP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // general registers: no reset, contents undefined until written
    generate
        for (genvar g = 0; g < GP_COUNT; g++) begin : g_gp
            always_comb begin
                nxt_gp[g] = gp_ff[g];
                if (I_GP_WR.we && I_GP_WR.idx == 4'(g)) begin
                    nxt_gp[g] = I_GP_WR.data;
                end
            end
            always_ff @(posedge I_CORE_CLK) begin
                gp_ff[g] <= nxt_gp[g];
            end
        end
    endgenerate

    // undefined-at-reset pointers, link and program counter
    always_comb begin
        nxt_main_ptr = main_ptr_ff;
        nxt_proc_ptr = proc_ptr_ff;
        nxt_lr = lr_ff;
        nxt_pc = pc_ff;
        if (state_ff == ST_FETCH_SP && I_VEC_VALID) begin
            nxt_main_ptr = I_VEC_DATA;
        end
        if (state_ff == ST_FETCH_PC && I_VEC_VALID) begin
            nxt_pc = I_VEC_DATA;
        end
        if (state_ff == ST_RUN && I_GP_WR.we) begin
            case (I_GP_WR.idx)
                IDX_SP: begin
                    if (active_proc) begin
                        nxt_proc_ptr = I_GP_WR.data;
                    end else begin
                        nxt_main_ptr = I_GP_WR.data;
                    end
                end
                IDX_LR: nxt_lr = I_GP_WR.data;
                IDX_PC: nxt_pc = I_GP_WR.data;
                default: ;
            endcase
        end
        // explicit main or process pointer move by instruction
        if (state_ff == ST_RUN && spec_wr_ok && I_SPEC.sel == SPEC_STACK) begin
            if (I_SPEC.proc_sel) begin
                nxt_proc_ptr = I_SPEC.data;
            end else begin
                nxt_main_ptr = I_SPEC.data;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        main_ptr_ff <= nxt_main_ptr;
        proc_ptr_ff <= nxt_proc_ptr;
        lr_ff <= nxt_lr;
        pc_ff <= nxt_pc;
    end

    // flags: undefined at reset, alu update wins over a software move
    always_comb begin
        nxt_flags = flags_ff;
        if (state_ff == ST_RUN && spec_wr_ok && I_SPEC.sel == SPEC_STATUS) begin
            case (I_SPEC.view)
                VIEW_FLAGS, VIEW_EXC_FLAG, VIEW_EXEC_FLAG, VIEW_ALL:
                    nxt_flags = I_SPEC.data[FLAG_N_BIT:FLAG_V_BIT];
                default: ;
            endcase
        end
        if (I_FLAGS_WE) begin
            nxt_flags = I_FLAGS;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        flags_ff <= nxt_flags;
    end

    // exception number, state bit, mask, control and fault
    always_comb begin
        nxt_exc = exc_ff;
        nxt_tbit = tbit_ff;
        nxt_prio_mask = prio_mask_ff;
        nxt_ctrl = ctrl_ff;
        nxt_fault = 1'b0;
        // software writes never touch exception number or state bit
        if (I_EXC_WE) begin
            nxt_exc = I_EXC_NUM;
        end
        if (state_ff == ST_FETCH_PC && I_VEC_VALID) begin
            nxt_tbit = I_VEC_DATA[0];
        end else if (I_TBIT_WE) begin
            nxt_tbit = I_TBIT;
        end
        if (state_ff == ST_RUN && spec_wr_ok) begin
            case (I_SPEC.sel)
                SPEC_PRIO_MASK: nxt_prio_mask = I_SPEC.data[0];
                SPEC_CONTROL: begin
                    nxt_ctrl[0] = I_SPEC.data[0];
                    if (!handler) begin
                        nxt_ctrl[1] = I_SPEC.data[1];
                    end
                end
                default: ;
            endcase
        end
        if (I_CTRL_HW_WE) begin
            nxt_ctrl = I_CTRL_HW;
        end
        if (state_ff == ST_RUN && I_EXEC_VALID && !tbit_ff) begin
            nxt_fault = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            exc_ff <= EXC_NUM_RST;
            tbit_ff <= 1'b0;
            prio_mask_ff <= PRIO_MASK_RST;
            ctrl_ff <= CONTROL_RST;
            fault_ff <= 1'b0;
        end else begin
            exc_ff <= nxt_exc;
            tbit_ff <= nxt_tbit;
            prio_mask_ff <= nxt_prio_mask;
            ctrl_ff <= nxt_ctrl;
            fault_ff <= nxt_fault;
        end
    end

    // read ports; index 13 aliases whichever pointer is active
    function automatic logic [31:0] rd_gp(input logic [3:0] idx);
        logic [31:0] r;
        r = 32'h00000000;
        if (idx == IDX_SP) begin
            r = active_sp;
        end else if (idx == IDX_LR) begin
            r = lr_ff;
        end else if (idx == IDX_PC) begin
            r = pc_ff;
        end else if (32'(idx) < GP_COUNT) begin
            r = gp_ff[idx];
        end
        return r;
    endfunction

    assign O_GP_RDATA_A = rd_gp(I_GP_RIDX_A);
    assign O_GP_RDATA_B = rd_gp(I_GP_RIDX_B);

    // special move read data
    always_comb begin
        case (I_SPEC.sel)
            SPEC_STATUS: O_SPEC_RDATA = view_rdata;
            SPEC_PRIO_MASK: O_SPEC_RDATA = {31'h0, prio_mask_ff};
            SPEC_CONTROL: O_SPEC_RDATA = {30'h00000000, ctrl_ff[1] && !handler, ctrl_ff[0]};
            SPEC_STACK: O_SPEC_RDATA = I_SPEC.proc_sel ? proc_ptr_ff : main_ptr_ff;
            default: O_SPEC_RDATA = 32'h00000000;
        endcase
    end

    assign O_RST_DONE = (state_ff == ST_RUN);
    assign O_HANDLER_MODE = handler;
    assign O_UNPRIV = ctrl_ff[0] && !handler;
    assign O_USE_PROC = active_proc;
    assign O_PRIO_MASK = prio_mask_ff;
    assign O_FLAGS = flags_ff;
    assign O_EXC_NUM = exc_ff;
    assign O_TBIT = tbit_ff;
    assign O_TBIT_FAULT = fault_ff;
endmodule

// >>> hdl/crsw_status_view.sv
/*
 * crsw_status_view: builds the composite status word read value for one view.
 * Assumes field contents come from the register file; purely combinational.
 */
`timescale 1ns/1ps
module crsw_status_view
    import crsw_pkg::*;
(
    input wire crsw_view_t i_view,
    input wire logic [3:0] i_flags,
    input wire logic [5:0] i_exc_num,
    output logic [31:0] o_rdata
);
    logic sel_flag;
    logic sel_exc;

    // pick the fields; execution state always reads zero to software
    always_comb begin
        sel_flag = 1'b0;
        sel_exc = 1'b0;
        case (i_view)
            VIEW_FLAGS: sel_flag = 1'b1;
            VIEW_EXC: sel_exc = 1'b1;
            VIEW_EXEC: ;
            VIEW_EXC_FLAG: begin
                sel_flag = 1'b1;
                sel_exc = 1'b1;
            end
            VIEW_EXEC_FLAG: sel_flag = 1'b1;
            VIEW_EXC_EXEC: sel_exc = 1'b1;
            VIEW_ALL: begin
                sel_flag = 1'b1;
                sel_exc = 1'b1;
            end
            default: ;
        endcase
        o_rdata = 32'h00000000;
        if (sel_flag) begin
            o_rdata[FLAG_N_BIT:FLAG_V_BIT] = i_flags;
        end
        if (sel_exc) begin
            o_rdata[EXC_NUM_W-1:0] = i_exc_num;
        end
    end
endmodule

// >>> tb/crsw_assertions.sv
/* crsw_assertions: concurrent checks on the core register set ports.
   Assumes it is bound to crsw_core_regs and sees only its ports. */
`timescale 1ns/1ps
module crsw_assertions
    import crsw_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic [31:0] O_VEC_ADDR,
    input wire logic O_VEC_REQ,
    input wire logic I_VEC_VALID,
    input wire logic [31:0] I_VEC_DATA,
    input wire logic O_RST_DONE,
    input wire crsw_spec_req_t I_SPEC,
    input wire logic [31:0] O_SPEC_RDATA,
    input wire logic I_EXC_WE,
    input wire logic [5:0] I_EXC_NUM,
    input wire logic I_EXEC_VALID,
    input wire logic O_HANDLER_MODE,
    input wire logic O_USE_PROC,
    input wire logic [3:0] O_FLAGS,
    input wire logic [5:0] O_EXC_NUM,
    input wire logic O_TBIT,
    input wire logic O_TBIT_FAULT
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    // the two vector fetches of the load sequence
    sequence sp_fetch_s;
        O_VEC_REQ && O_VEC_ADDR == ADDR_SP_VEC && I_VEC_VALID && !O_RST_DONE;
    endsequence
    sequence pc_fetch_s;
        O_VEC_REQ && O_VEC_ADDR == ADDR_RESET_VEC && I_VEC_VALID && !O_RST_DONE;
    endsequence
    wire st_rd = I_SPEC.sel == SPEC_STATUS && !I_SPEC.we;
    sp_then_pc_a: assert property (sp_fetch_s |=> O_VEC_REQ && O_VEC_ADDR == ADDR_RESET_VEC)
        else $error("second vector word not requested");
    load_done_a: assert property (pc_fetch_s |=> O_RST_DONE && O_TBIT == $past(I_VEC_DATA[0]))
        else $error("state bit not taken from reset vector");
    exc_load_a: assert property (I_EXC_WE |=> O_EXC_NUM == $past(I_EXC_NUM))
        else $error("exception number not loaded");
    exc_keep_a: assert property (I_SPEC.we && I_SPEC.sel == SPEC_STATUS && !I_EXC_WE |=> $stable(O_EXC_NUM))
        else $error("status write changed exception number");
    handler_main_a: assert property (O_HANDLER_MODE == (O_EXC_NUM != 6'h00) && !(O_HANDLER_MODE && O_USE_PROC))
        else $error("handler mode not on main pointer");
    exec_zero_a: assert property (st_rd |-> (O_SPEC_RDATA & ~(FLAG_MASK | EXC_MASK)) == 32'h0)
        else $error("status read shows state or reserved bits");
    flag_view_a: assert property (st_rd && I_SPEC.view == VIEW_FLAGS |-> O_SPEC_RDATA == {O_FLAGS, 28'h0})
        else $error("flag view wrong");
    exc_view_a: assert property (st_rd && I_SPEC.view == VIEW_EXC |-> O_SPEC_RDATA == {26'h0, O_EXC_NUM})
        else $error("exception view wrong");
    fault_raise_a: assert property (I_EXEC_VALID && !O_TBIT && O_RST_DONE |=> O_TBIT_FAULT)
        else $error("no fault with state bit clear");
    fault_cause_a: assert property (O_TBIT_FAULT |-> $past(I_EXEC_VALID) && !$past(O_TBIT))
        else $error("fault without cause");
endmodule
bind crsw_core_regs crsw_assertions u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
    .O_VEC_ADDR(O_VEC_ADDR), .O_VEC_REQ(O_VEC_REQ), .I_VEC_VALID(I_VEC_VALID), .I_VEC_DATA(I_VEC_DATA),
    .O_RST_DONE(O_RST_DONE), .I_SPEC(I_SPEC), .O_SPEC_RDATA(O_SPEC_RDATA), .I_EXC_WE(I_EXC_WE),
    .I_EXC_NUM(I_EXC_NUM), .I_EXEC_VALID(I_EXEC_VALID), .O_HANDLER_MODE(O_HANDLER_MODE),
    .O_USE_PROC(O_USE_PROC), .O_FLAGS(O_FLAGS), .O_EXC_NUM(O_EXC_NUM), .O_TBIT(O_TBIT),
    .O_TBIT_FAULT(O_TBIT_FAULT));

// >>> tb/crsw_core_regs_tb.sv
/* crsw_core_regs_tb: directed tests of the core register set.
   Assumes crsw_vec_model supplies vectors and the checker is bound. */
`timescale 1ns/1ps
module crsw_core_regs_tb
    import crsw_pkg::*;
;
    localparam logic [31:0] SP_W = 32'h20001000;
    localparam logic [31:0] PC_W = 32'h00000101;
    logic core_clk, resetn, vec_req, vec_valid, rst_done, flags_we, exc_we, tbit_we, tbit, ctrl_hw_we, exec_valid;
    logic handler, unpriv, use_proc, prio_mask, o_tbit, tfault;
    logic [31:0] vec_addr, vec_data, rd_a, rd_b, spec_rdata;
    logic [3:0] ridx_a, ridx_b, flags, o_flags, wait_cy;
    logic [5:0] exc_num, o_exc;
    logic [1:0] ctrl_hw;
    crsw_gpw_t gp_wr;
    crsw_spec_req_t spec;
    int mismatches, num_checks, cycles;
    logic [5:0] codes [8] = '{EXC_THREAD, EXC_NMI, EXC_HARD_FAULT, EXC_SUPERVISOR_CALL,
        EXC_PENDABLE_SERVICE, EXC_SYSTEM_TICK, EXC_EXT_IRQ_FIRST, EXC_EXT_IRQ_LAST};

    crsw_core_regs uut (.I_CORE_CLK(core_clk), .I_RESETN(resetn), .O_VEC_ADDR(vec_addr),
        .O_VEC_REQ(vec_req), .I_VEC_VALID(vec_valid), .I_VEC_DATA(vec_data), .O_RST_DONE(rst_done),
        .I_GP_WR(gp_wr), .I_GP_RIDX_A(ridx_a), .I_GP_RIDX_B(ridx_b), .O_GP_RDATA_A(rd_a),
        .O_GP_RDATA_B(rd_b), .I_FLAGS_WE(flags_we), .I_FLAGS(flags), .I_SPEC(spec),
        .O_SPEC_RDATA(spec_rdata), .I_EXC_WE(exc_we), .I_EXC_NUM(exc_num), .I_TBIT_WE(tbit_we),
        .I_TBIT(tbit), .I_CTRL_HW_WE(ctrl_hw_we), .I_CTRL_HW(ctrl_hw), .I_EXEC_VALID(exec_valid),
        .O_HANDLER_MODE(handler), .O_UNPRIV(unpriv), .O_USE_PROC(use_proc), .O_PRIO_MASK(prio_mask),
        .O_FLAGS(o_flags), .O_EXC_NUM(o_exc), .O_TBIT(o_tbit), .O_TBIT_FAULT(tfault));
    crsw_vec_model #(.SP_WORD(SP_W), .PC_WORD(PC_W)) u_vec (.i_clk(core_clk), .i_rstn(resetn),
        .i_req(vec_req), .i_addr(vec_addr), .i_wait(wait_cy), .o_valid(vec_valid), .o_data(vec_data));

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    // hang guard, far above the hundred or so cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge after each write, so the next call never retimes the strobe in the same step
    task automatic spec_wr(input crsw_spec_t sel, input crsw_view_t view, input logic proc, input logic [31:0] d);
        spec = '{1'h1, sel, view, proc, d};
        @(negedge core_clk);
        spec.we = 1'h0;
        @(negedge core_clk);
    endtask
    task automatic spec_rd(input crsw_spec_t sel, input crsw_view_t view, input logic proc, input logic [31:0] e);
        spec = '{1'h0, sel, view, proc, 32'h0};
        #1;
        chk(spec_rdata, e);
        @(negedge core_clk);
    endtask
    // reset, then a move attempted before the load ends must be refused
    task automatic do_reset(input logic [3:0] w);
        wait_cy = w;
        resetn = 1'h0;
        repeat (5) @(negedge core_clk);
        chk(32'({vec_req, rst_done, o_exc, prio_mask, tfault}), 32'h200);
        chk(vec_addr, ADDR_SP_VEC);
        resetn = 1'h1;
        spec_wr(SPEC_PRIO_MASK, VIEW_FLAGS, 1'h0, 32'h1);
        for (int i = 0; i < 40 && rst_done !== 1'h1; i++) @(negedge core_clk);
        ridx_a = IDX_SP;
        ridx_b = IDX_PC;
        #1;
        chk(rd_a, SP_W);
        chk({rd_b[31:1], 1'h0}, {PC_W[31:1], 1'h0});
        chk(32'({rst_done, o_tbit}), 32'h3);
        spec_rd(SPEC_PRIO_MASK, VIEW_FLAGS, 1'h0, 32'h0);
        spec_rd(SPEC_CONTROL, VIEW_FLAGS, 1'h0, 32'h0);
    endtask

    initial begin
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        resetn = 1'h0;
        gp_wr = '0;
        spec = '{1'h0, SPEC_PRIO_MASK, VIEW_FLAGS, 1'h0, 32'h0};
        {ridx_a, ridx_b, flags_we, flags, exc_we, exc_num, tbit_we, tbit} = '0;
        {ctrl_hw_we, ctrl_hw, exec_valid, wait_cy} = '0;
        @(negedge core_clk);
        do_reset(4'h0);
        spec_wr(SPEC_PRIO_MASK, VIEW_FLAGS, 1'h0, 32'h1);
        chk(32'(prio_mask), 32'h1);
        // back-to-back writes over indices 0..14, 13 being the main pointer here
        for (int i = 0; i < 15; i++) begin
            gp_wr = '{1'h1, 4'(i), 32'hC0DE0000 | 32'(i)};
            @(negedge core_clk);
            gp_wr.we = 1'h0;
            ridx_a = 4'(i);
            ridx_b = 4'(i);
            #1;
            chk(rd_a, 32'hC0DE0000 | 32'(i));
            chk(rd_b, 32'hC0DE0000 | 32'(i));
        end
        spec_wr(SPEC_STACK, VIEW_FLAGS, 1'h0, 32'h1000);
        spec_wr(SPEC_STACK, VIEW_FLAGS, 1'h1, 32'h2000);
        spec_rd(SPEC_STACK, VIEW_FLAGS, 1'h0, 32'h1000);
        spec_rd(SPEC_STACK, VIEW_FLAGS, 1'h1, 32'h2000);
        ctrl_hw_we = 1'h1;
        ctrl_hw = 2'h3;
        @(negedge core_clk);
        ctrl_hw_we = 1'h0;
        ridx_a = IDX_SP;
        #1;
        chk(rd_a, 32'h2000);
        chk(32'({use_proc, unpriv}), 32'h3);
        spec_wr(SPEC_CONTROL, VIEW_FLAGS, 1'h0, 32'h0);
        chk(rd_a, 32'h1000);
        chk(32'({use_proc, unpriv}), 32'h0);
        // handler mode drops a write of the stack select bit
        exc_we = 1'h1;
        exc_num = EXC_SUPERVISOR_CALL;
        @(negedge core_clk);
        exc_we = 1'h0;
        spec_wr(SPEC_CONTROL, VIEW_FLAGS, 1'h0, 32'h2);
        spec_rd(SPEC_CONTROL, VIEW_FLAGS, 1'h0, 32'h0);
        foreach (codes[k]) begin
            exc_we = 1'h1;
            exc_num = codes[k];
            @(negedge core_clk);
            exc_we = 1'h0;
            spec_rd(SPEC_STATUS, VIEW_EXC, 1'h0, 32'(codes[k]));
            chk(32'(handler), 32'(codes[k] != 6'h0));
            if (codes[k] == EXC_THREAD) spec_rd(SPEC_CONTROL, VIEW_FLAGS, 1'h0, 32'h0);
        end
        // status views: exception number and state bit survive every write
        flags_we = 1'h1;
        flags = 4'hA;
        @(negedge core_clk);
        flags_we = 1'h0;
        chk(32'(o_flags), 32'hA);
        spec_wr(SPEC_STATUS, VIEW_ALL, 1'h0, 32'h5E000001);
        spec_wr(SPEC_STATUS, VIEW_EXC_FLAG, 1'h0, 32'h90000005);
        spec_wr(SPEC_STATUS, VIEW_EXEC_FLAG, 1'h0, 32'h30000000);
        spec_wr(SPEC_STATUS, VIEW_EXC_EXEC, 1'h0, 32'hF0000000);
        chk(32'({o_flags, o_exc, o_tbit}), 32'h1DF);
        for (int v = 0; v < 7; v++) spec_rd(SPEC_STATUS, crsw_view_t'(v), 1'h0,
            ((v inside {0, 3, 4, 6}) ? 32'h30000000 : 32'h0) | ((v inside {1, 3, 5, 6}) ? 32'h2F : 32'h0));
        // clear the state bit while executing, fault follows one cycle later
        exec_valid = 1'h1;
        tbit_we = 1'h1;
        @(negedge core_clk);
        tbit_we = 1'h0;
        chk(32'({o_tbit, tfault}), 32'h0);
        @(negedge core_clk);
        exec_valid = 1'h0;
        chk(32'(tfault), 32'h1);
        @(negedge core_clk);
        chk(32'(tfault), 32'h0);
        do_reset(4'h6);
        final_report();
    end
endmodule

// >>> tb/crsw_vec_model.sv
/* crsw_vec_model: vector word supplier answering fetches of the reset load.
   Assumes the request is held until answered; i_wait sets idle cycles. */
`timescale 1ns/1ps
module crsw_vec_model
    import crsw_pkg::*;
#(
    parameter logic [31:0] SP_WORD = 32'h20001000,
    parameter logic [31:0] PC_WORD = 32'h00000101
)(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic [3:0] i_wait,
    output logic o_valid,
    output logic [31:0] o_data
);
    logic [3:0] wcnt;
    // one-cycle answer; data churns otherwise so a stale word never looks valid
    always @(posedge i_clk) begin
        if (!i_rstn || o_valid) begin
            o_valid <= 1'h0;
            wcnt <= 4'h0;
            o_data <= ~o_data;
        end else if (i_req && wcnt >= i_wait) begin
            o_valid <= 1'h1;
            o_data <= (i_addr == ADDR_SP_VEC) ? SP_WORD : PC_WORD;
        end else begin
            wcnt <= wcnt + 4'h1;
            o_data <= ~o_data;
        end
    end
    initial begin
        o_valid = 1'h0;
        o_data = 32'h0;
        wcnt = 4'h0;
    end
endmodule
